//--- core/crs_pkg.sv
// constants for the processor register set and condition flags
`default_nettype none
package crs_pkg;
    // register indices on the software port
    localparam logic [4:0] IDX_ACC_FIRST = 5'h00;
    localparam logic [4:0] IDX_ACC_SECOND = 5'h01;
    localparam logic [4:0] IDX_ACC_DOUBLE = 5'h02;
    localparam logic [4:0] IDX_ACC_EXTRA = 5'h03;
    localparam logic [4:0] IDX_INDEX_ONE = 5'h04;
    localparam logic [4:0] IDX_INDEX_TWO = 5'h05;
    localparam logic [4:0] IDX_INDEX_THREE = 5'h06;
    localparam logic [4:0] IDX_STACK = 5'h07;
    localparam logic [4:0] IDX_PROGRAM = 5'h08;
    localparam logic [4:0] IDX_FLAGS = 5'h09;
    localparam logic [4:0] IDX_BANKS = 5'h0a;
    localparam logic [4:0] IDX_STACK_BANK = 5'h0b;
    localparam logic [4:0] IDX_MULTIPLIER = 5'h0c;
    localparam logic [4:0] IDX_MULTIPLICAND = 5'h0d;
    localparam logic [4:0] IDX_MAC_HIGH = 5'h0e;
    localparam logic [4:0] IDX_MAC_LOW = 5'h0f;
    localparam logic [4:0] IDX_MASKS = 5'h10;
    localparam logic [4:0] IDX_MAC_SAT_READ = 5'h11;
    // condition register bit positions
    localparam int FLG_STOP_EN = 15;
    localparam int FLG_MV = 14;
    localparam int FLG_HALF = 13;
    localparam int FLG_EV = 12;
    localparam int FLG_NEG = 11;
    localparam int FLG_ZERO = 10;
    localparam int FLG_OVF = 9;
    localparam int FLG_CARRY = 8;
    localparam int FLG_PRIO_LSB = 5;
    localparam int FLG_SAT = 4;
    // bank register field positions
    localparam int BANK_EXT_LSB = 12;
    localparam int BANK_ONE_LSB = 8;
    localparam int BANK_TWO_LSB = 4;
    localparam int BANK_THREE_LSB = 0;
    // reset values
    localparam logic [15:0] RST_FLAGS = 16'h80e0;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0] RST_BANK = 4'h0;
    // saturation limits of the 36-bit accumulator
    localparam logic [35:0] MAC_MAX_POS = 36'h7ffffffff;
    localparam logic [35:0] MAC_MAX_NEG = 36'h800000000;
    // stack step sizes
    localparam logic [19:0] STEP_WORD = 20'h00002;
    localparam logic [19:0] STEP_BYTE = 20'h00001;
endpackage
`default_nettype wire

//--- core/crs_regs.sv
// programmer-visible register set, bank extensions and condition flags
//
// The strobed register port and the register offsets were left to the implementer.
`default_nettype none
// Summary of operation
// - two 8-bit accumulators plus a separate 16-bit accumulator
// - first and second accumulators pair as a 16-bit word, first on top
// - extra accumulator usable wherever the pair is, including indexed offset
// - three 16-bit index registers, each with a 4-bit bank field
// - index register and its bank form a 20-bit address
// - reset loads third index register and bank from the reset vector
// - 16-bit stack pointer with 4-bit bank forms a 20-bit stack address
// - stack address decrements on push, increments on pull
// - stack address always points at next free location
// - word or byte stack steps; odd pointer values accepted
// - 16-bit program counter with 4-bit bank forms a 20-bit address
// - fetch address bit 0 forced to zero
// - condition register layout: stop, MV, H, EV, N, Z, V, C, prio, sat, bank
// - stop instruction halts clock when stop enable is 0, else no-op
// - mac overflow flag set on overflow into accumulator bit 35
// - mac extension overflow flag set on overflow into bit 31
// - half carry set on carry out of bit 3 during decimal add
// - negative set from msb of operand or result
// - zero set when operand or result is all zero
// - overflow set on two's complement signed overflow
// - carry set on carry or borrow and passed through in shifts
// - one flat one-megabyte space of sixteen 64-Kbyte banks
// - 3-bit priority field is the interrupt mask level
// - saturate mode clamps the saturated accumulator read slot after overflow by original sign
// - program bank field sits above program counter for fetch address
// - mac unit holds multiplier, multiplicand, 36-bit accumulator, two masks
module crs_regs (
    input wire logic mclk,
    input wire logic nrst,
    // software register port
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // reset vector contents for the third index pair
    input wire logic [15:0] rst_index_three,
    input wire logic [3:0] rst_index_three_bank,
    // stack control from execution
    input wire logic stack_push,
    input wire logic stack_pull,
    input wire logic stack_byte,
    // program counter control
    input wire logic pc_load,
    input wire logic [15:0] pc_value,
    input wire logic pc_step,
    // flag update from execution: value and per-flag update enable for bits 15..8
    input wire logic [7:0] flag_upd,
    input wire logic [7:0] flag_val,
    // raw event conditions
    input wire logic decimal_add,
    input wire logic carry_bit3_first,
    input wire logic carry_bit3_second,
    input wire logic mac_load,
    input wire logic [35:0] mac_value,
    input wire logic [35:0] mac_prev,
    input wire logic low_power_stop_instruction,
    output logic [19:0] fetch_addr,
    output logic [19:0] stack_addr,
    output logic [19:0] index_one_addr,
    output logic [19:0] index_two_addr,
    output logic [19:0] index_three_addr,
    output logic [15:0] acc_double,
    output logic [15:0] acc_extra,
    output logic [2:0] interrupt_priority_mask,
    output logic clock_stop
);
    logic rst_meta_r;
    logic rst_sync_r;
    logic [7:0] acc_first_r;
    logic [7:0] acc_second_r;
    logic [15:0] acc_extra_r;
    logic [15:0] index_one_r;
    logic [15:0] index_two_r;
    logic [15:0] index_three_r;
    logic [15:0] stack_r;
    logic [15:0] pc_r;
    logic [15:0] flags_r;
    logic [15:0] banks_r;
    logic [3:0] stack_bank_r;
    logic [15:0] mult_r;
    logic [15:0] mcand_r;
    logic [35:0] mac_r;
    logic [15:0] masks_r;
    logic strap_pend_r;
    logic [19:0] stack_full;
    logic [19:0] stack_nxt;
    logic [35:0] mac_sat;
    logic mv_set;
    logic ev_set;
    logic half_set;
    logic [15:0] rd_nxt;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    logic wr_en;
    assign wr_en = reg_wr;

    // accumulators
    always_ff @(posedge mclk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            acc_first_r <= 8'h00;
            acc_second_r <= 8'h00;
            acc_extra_r <= crs_pkg::RST_WORD;
        end
        else if (wr_en)
        begin
            case (reg_addr)
                crs_pkg::IDX_ACC_FIRST: acc_first_r <= reg_wdata[7:0];
                crs_pkg::IDX_ACC_SECOND: acc_second_r <= reg_wdata[7:0];
                crs_pkg::IDX_ACC_DOUBLE:
                begin
                    acc_first_r <= reg_wdata[15:8];
                    acc_second_r <= reg_wdata[7:0];
                end
                crs_pkg::IDX_ACC_EXTRA: acc_extra_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // index registers; third pair caught from reset vector after release
    always_ff @(posedge mclk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            index_one_r <= crs_pkg::RST_WORD;
            index_two_r <= crs_pkg::RST_WORD;
            index_three_r <= crs_pkg::RST_WORD;
            banks_r <= crs_pkg::RST_WORD;
            strap_pend_r <= 1'b1;
        end
        else if (strap_pend_r)
        begin
            // software index writes are dropped in this one cycle
            index_three_r <= rst_index_three;
            banks_r[crs_pkg::BANK_THREE_LSB +: 4] <= rst_index_three_bank;
            strap_pend_r <= 1'b0;
        end
        else if (wr_en)
        begin
            case (reg_addr)
                crs_pkg::IDX_INDEX_ONE: index_one_r <= reg_wdata;
                crs_pkg::IDX_INDEX_TWO: index_two_r <= reg_wdata;
                crs_pkg::IDX_INDEX_THREE: index_three_r <= reg_wdata;
                crs_pkg::IDX_BANKS: banks_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // stack pointer, 20-bit arithmetic across the bank boundary
    assign stack_full = {stack_bank_r, stack_r};
    always_comb
    begin
        stack_nxt = stack_full;
        if (stack_push && !stack_pull)
            stack_nxt = stack_full - (stack_byte ? crs_pkg::STEP_BYTE : crs_pkg::STEP_WORD);
        else if (stack_pull && !stack_push)
            stack_nxt = stack_full + (stack_byte ? crs_pkg::STEP_BYTE : crs_pkg::STEP_WORD);
    end

    always_ff @(posedge mclk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            stack_r <= crs_pkg::RST_WORD;
            stack_bank_r <= crs_pkg::RST_BANK;
        end
        // software write to the pointer wins over a push or pull
        else if (wr_en && reg_addr == crs_pkg::IDX_STACK)
            stack_r <= reg_wdata;
        else if (wr_en && reg_addr == crs_pkg::IDX_STACK_BANK)
            stack_bank_r <= reg_wdata[3:0];
        else
        begin
            stack_r <= stack_nxt[15:0];
            stack_bank_r <= stack_nxt[19:16];
        end
    end

    // program counter, steps one word per fetch
    always_ff @(posedge mclk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            pc_r <= crs_pkg::RST_WORD;
        // execution load outranks software write and step
        else if (pc_load)
            pc_r <= pc_value;
        else if (wr_en && reg_addr == crs_pkg::IDX_PROGRAM)
            pc_r <= reg_wdata;
        else if (pc_step)
            pc_r <= pc_r + crs_pkg::STEP_WORD[15:0];
    end

    // mac register set
    always_comb
    begin
        // a sign flip from a value whose top two bits differ is an overflow;
        // a flip from a small value is an ordinary zero crossing
        mv_set = mac_load && (mac_value[35] != mac_prev[35]) && (mac_prev[35] != mac_prev[34]);
        ev_set = mac_load && (mac_value[35:31] != {5{mac_value[35]}});
        half_set = decimal_add && (carry_bit3_first || carry_bit3_second);
    end

    always_ff @(posedge mclk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            mult_r <= crs_pkg::RST_WORD;
            mcand_r <= crs_pkg::RST_WORD;
            mac_r <= 36'h000000000;
            masks_r <= crs_pkg::RST_WORD;
        end
        else if (mac_load)
            mac_r <= mac_value;
        else if (wr_en)
        begin
            case (reg_addr)
                crs_pkg::IDX_MULTIPLIER: mult_r <= reg_wdata;
                crs_pkg::IDX_MULTIPLICAND: mcand_r <= reg_wdata;
                crs_pkg::IDX_MAC_HIGH: mac_r[35:16] <= {reg_wdata[3:0], reg_wdata};
                crs_pkg::IDX_MAC_LOW: mac_r[15:0] <= reg_wdata;
                crs_pkg::IDX_MASKS: masks_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    // condition flags; MV, EV and H set events win over a software write
    always_ff @(posedge mclk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            flags_r <= crs_pkg::RST_FLAGS;
        else
        begin
            if (wr_en && reg_addr == crs_pkg::IDX_FLAGS)
                flags_r <= reg_wdata;
            else
            begin
                for (int i = 0; i < 8; i++)
                begin
                    if (flag_upd[i])
                        flags_r[crs_pkg::FLG_CARRY + i] <= flag_val[i];
                end
            end
            // set events last, so they beat a clear in the same cycle
            if (mv_set)
                flags_r[crs_pkg::FLG_MV] <= 1'b1;
            if (ev_set)
                flags_r[crs_pkg::FLG_EV] <= 1'b1;
            if (half_set)
                flags_r[crs_pkg::FLG_HALF] <= 1'b1;
        end
    end

    // saturated accumulator view
    always_comb
    begin
        mac_sat = mac_r;
        // bit 35 xor the overflow flag is the sign before the overflow
        if (flags_r[crs_pkg::FLG_SAT] && (flags_r[crs_pkg::FLG_MV] || flags_r[crs_pkg::FLG_EV]))
            mac_sat = mac_r[35] ^ flags_r[crs_pkg::FLG_MV] ? crs_pkg::MAC_MAX_NEG : crs_pkg::MAC_MAX_POS;
    end

    always_comb
    begin
        // unmapped slots read as zero
        rd_nxt = 16'h0000;
        case (reg_addr)
            crs_pkg::IDX_ACC_FIRST: rd_nxt = {8'h00, acc_first_r};
            crs_pkg::IDX_ACC_SECOND: rd_nxt = {8'h00, acc_second_r};
            crs_pkg::IDX_ACC_DOUBLE: rd_nxt = {acc_first_r, acc_second_r};
            crs_pkg::IDX_ACC_EXTRA: rd_nxt = acc_extra_r;
            crs_pkg::IDX_INDEX_ONE: rd_nxt = index_one_r;
            crs_pkg::IDX_INDEX_TWO: rd_nxt = index_two_r;
            crs_pkg::IDX_INDEX_THREE: rd_nxt = index_three_r;
            crs_pkg::IDX_STACK: rd_nxt = stack_r;
            crs_pkg::IDX_PROGRAM: rd_nxt = pc_r;
            crs_pkg::IDX_FLAGS: rd_nxt = flags_r;
            crs_pkg::IDX_BANKS: rd_nxt = banks_r;
            crs_pkg::IDX_STACK_BANK: rd_nxt = {12'h000, stack_bank_r};
            crs_pkg::IDX_MULTIPLIER: rd_nxt = mult_r;
            crs_pkg::IDX_MULTIPLICAND: rd_nxt = mcand_r;
            crs_pkg::IDX_MAC_HIGH: rd_nxt = {12'h000, mac_r[35:32]};
            crs_pkg::IDX_MAC_LOW: rd_nxt = mac_r[15:0];
            crs_pkg::IDX_MASKS: rd_nxt = masks_r;
            crs_pkg::IDX_MAC_SAT_READ: rd_nxt = mac_sat[31:16];
            default: rd_nxt = 16'h0000;
        endcase
    end

    // registered outputs
    always_ff @(posedge mclk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            reg_rdata <= 16'h0000;
            fetch_addr <= 20'h00000;
            stack_addr <= 20'h00000;
            index_one_addr <= 20'h00000;
            index_two_addr <= 20'h00000;
            index_three_addr <= 20'h00000;
            acc_double <= 16'h0000;
            acc_extra <= 16'h0000;
            interrupt_priority_mask <= 3'h7;
            clock_stop <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_rd ? rd_nxt : 16'h0000;
            fetch_addr <= {flags_r[3:0], pc_r[15:1], 1'b0};
            stack_addr <= stack_full;
            index_one_addr <= {banks_r[crs_pkg::BANK_ONE_LSB +: 4], index_one_r};
            index_two_addr <= {banks_r[crs_pkg::BANK_TWO_LSB +: 4], index_two_r};
            index_three_addr <= {banks_r[crs_pkg::BANK_THREE_LSB +: 4], index_three_r};
            acc_double <= {acc_first_r, acc_second_r};
            acc_extra <= acc_extra_r;
            interrupt_priority_mask <= flags_r[crs_pkg::FLG_PRIO_LSB +: 3];
            clock_stop <= low_power_stop_instruction && !flags_r[crs_pkg::FLG_STOP_EN];
        end
    end
endmodule
`default_nettype wire

//--- verification/crs_exec_model.sv
// execution-side model issuing stack, program counter, flag and mac events
`default_nettype none
module crs_exec_model (
    input wire logic mclk,
    output logic stack_push,
    output logic stack_pull,
    output logic stack_byte,
    output logic pc_load,
    output logic [15:0] pc_value,
    output logic pc_step,
    output logic [7:0] flag_upd,
    output logic [7:0] flag_val,
    output logic decimal_add,
    output logic carry_bit3_first,
    output logic carry_bit3_second,
    output logic mac_load,
    output logic [35:0] mac_value,
    output logic [35:0] mac_prev,
    output logic low_power_stop_instruction
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        {stack_push, stack_pull, stack_byte, pc_load, pc_value, pc_step, flag_upd, flag_val} = '0;
        {decimal_add, carry_bit3_first, carry_bit3_second, low_power_stop_instruction} = 4'h0;
        {mac_load, mac_value, mac_prev} = '0;
    end
    // bits: push, pull, byte size
    task automatic stack_op(input logic [2:0] pps);
        @(posedge mclk);
        {stack_push, stack_pull, stack_byte} <= pps;
        @(posedge mclk);
        {stack_push, stack_pull, stack_byte} <= 3'h0;
    endtask
    // bits: load, step; released value bus shows the inverse
    task automatic pc_op(input logic [1:0] ls, input logic [15:0] v);
        @(posedge mclk);
        {pc_load, pc_step} <= ls;
        pc_value <= v;
        @(posedge mclk);
        {pc_load, pc_step} <= 2'h0;
        pc_value <= ~v;
    endtask
    // m bits: stop, decimal add, carry from first, carry from second
    task automatic flag_op(input logic [7:0] u, input logic [7:0] v, input logic [3:0] m);
        @(posedge mclk);
        flag_upd <= u;
        flag_val <= v;
        {low_power_stop_instruction, decimal_add, carry_bit3_first, carry_bit3_second} <= m;
        @(posedge mclk);
        flag_upd <= 8'h00;
        flag_val <= ~v;
        {low_power_stop_instruction, decimal_add, carry_bit3_first, carry_bit3_second} <= 4'h0;
    endtask
    task automatic mac_op(input logic [35:0] v, input logic [35:0] p);
        @(posedge mclk);
        mac_load <= 1'b1;
        mac_value <= v;
        mac_prev <= p;
        @(posedge mclk);
        mac_load <= 1'b0;
        mac_value <= ~v;
        mac_prev <= ~p;
    endtask
endmodule
`default_nettype wire

//--- verification/crs_regs_chk.sv
// port-level assertions for the register set and condition flags
`default_nettype none
module crs_regs_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] rst_index_three,
    input wire logic [3:0] rst_index_three_bank,
    input wire logic stack_push,
    input wire logic stack_pull,
    input wire logic stack_byte,
    input wire logic low_power_stop_instruction,
    input wire logic [19:0] fetch_addr,
    input wire logic [19:0] stack_addr,
    input wire logic [19:0] index_three_addr,
    input wire logic [15:0] acc_double,
    input wire logic [15:0] acc_extra,
    input wire logic [2:0] interrupt_priority_mask,
    input wire logic clock_stop
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking dck @(posedge mclk);
    endclocking
    default disable iff (!nrst);
    AST_DOUBLE_WR: assert property (reg_wr && reg_addr == crs_pkg::IDX_ACC_DOUBLE |->
        ##2 acc_double == $past(reg_wdata, 2)) else $error("double accumulator write lost");
    AST_DOUBLE_RD: assert property (reg_rd && reg_addr == crs_pkg::IDX_ACC_DOUBLE |=>
        reg_rdata == acc_double) else $error("double accumulator read differs");
    AST_EXTRA_RD: assert property (reg_rd && reg_addr == crs_pkg::IDX_ACC_EXTRA |=>
        reg_rdata == acc_extra) else $error("extra accumulator read differs");
    AST_PUSH: assert property (stack_push && !stack_pull && !reg_wr |-> ##2 stack_addr ==
        $past(stack_addr) - ($past(stack_byte, 2) ? crs_pkg::STEP_BYTE : crs_pkg::STEP_WORD))
        else $error("push step wrong");
    AST_PULL: assert property (stack_pull && !stack_push && !reg_wr |-> ##2 stack_addr ==
        $past(stack_addr) + ($past(stack_byte, 2) ? crs_pkg::STEP_BYTE : crs_pkg::STEP_WORD))
        else $error("pull step wrong");
    AST_PC_RD: assert property (reg_rd && reg_addr == crs_pkg::IDX_PROGRAM |=>
        reg_rdata[15:1] == fetch_addr[15:1] && fetch_addr[0] == 1'b0) else $error("fetch address wrong");
    AST_FLAGS_RD: assert property (reg_rd && reg_addr == crs_pkg::IDX_FLAGS |=>
        reg_rdata[7:5] == interrupt_priority_mask && reg_rdata[3:0] == fetch_addr[19:16])
        else $error("flag fields differ from outputs");
    AST_STOP: assert property (clock_stop |->
        $past(low_power_stop_instruction) || $past(low_power_stop_instruction, 2)) else $error("stray stop");
    AST_IDX3_RESET: assert property ($rose(nrst) |->
        ##[3:6] index_three_addr == {rst_index_three_bank, rst_index_three}) else $error("strap not loaded");
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    cover property (reg_wr && reg_addr == crs_pkg::IDX_ACC_DOUBLE);
    cover property (stack_push && stack_byte);
    cover property (clock_stop);
endmodule
bind crs_regs crs_regs_chk i_crs_regs_chk (
    .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rst_index_three,
    .rst_index_three_bank, .stack_push, .stack_pull, .stack_byte, .low_power_stop_instruction,
    .fetch_addr, .stack_addr, .index_three_addr, .acc_double, .acc_extra, .interrupt_priority_mask,
    .clock_stop
);
`default_nettype wire

//--- verification/test_cpu_register_set_and_flags.sv
// self-checking bench for the register set and condition flags
`default_nettype none
module test_cpu_register_set_and_flags;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata, acc_double, acc_extra, pc_value, d;
    logic stack_push, stack_pull, stack_byte, pc_load, pc_step, decimal_add, carry_bit3_first;
    logic carry_bit3_second, mac_load, low_power_stop_instruction, clock_stop, seen;
    logic [7:0] flag_upd, flag_val;
    logic [35:0] mac_value, mac_prev;
    logic [19:0] fetch_addr, stack_addr, index_one_addr, index_two_addr, index_three_addr;
    logic [2:0] interrupt_priority_mask;
    logic [2:0] ops [5] = '{3'h4, 3'h5, 3'h6, 3'h3, 3'h2};
    logic [19:0] exps [5] = '{20'h2fffe, 20'h2fffd, 20'h2fffd, 20'h2fffe, 20'h30000};
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    always #25 mclk = ~mclk;
    crs_regs i_crs_regs (
        .mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .rst_index_three(16'hbeef), .rst_index_three_bank(4'ha),
        .stack_push, .stack_pull, .stack_byte, .pc_load, .pc_value, .pc_step, .flag_upd, .flag_val,
        .decimal_add, .carry_bit3_first, .carry_bit3_second, .mac_load, .mac_value, .mac_prev,
        .low_power_stop_instruction, .fetch_addr, .stack_addr, .index_one_addr, .index_two_addr,
        .index_three_addr, .acc_double, .acc_extra, .interrupt_priority_mask, .clock_stop
    );
    crs_exec_model i_crs_exec_model (
        .mclk, .stack_push, .stack_pull, .stack_byte, .pc_load, .pc_value, .pc_step, .flag_upd,
        .flag_val, .decimal_add, .carry_bit3_first, .carry_bit3_second, .mac_load, .mac_value,
        .mac_prev, .low_power_stop_instruction
    );
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // read, mask and compare; data stands only in the slot after the strobe
    task automatic rc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] exp);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, exp);
    endtask
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic watch(output logic s);
        s = 1'b0;
        repeat (4)
        begin
            #1 s = s | clock_stop;
            @(posedge mclk);
        end
    endtask
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            errors++;
            close_out();
        end
    end
    initial
    begin
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        repeat (5) @(posedge mclk);
        #1 chk(interrupt_priority_mask, 3'h7);
        chk(index_three_addr, 20'habeef);
        rc(crs_pkg::IDX_FLAGS, 16'hffff, crs_pkg::RST_FLAGS);
        wr(crs_pkg::IDX_ACC_FIRST, 16'h00ab);
        wr(crs_pkg::IDX_ACC_SECOND, 16'h00cd);
        wr(crs_pkg::IDX_ACC_EXTRA, 16'h5a5a);
        rc(crs_pkg::IDX_ACC_DOUBLE, 16'hffff, 16'habcd);
        chk(acc_double, 20'h0abcd);
        chk(acc_extra, 20'h05a5a);
        wr(crs_pkg::IDX_ACC_DOUBLE, 16'h1234);
        rc(crs_pkg::IDX_ACC_FIRST, 16'h00ff, 16'h0012);
        rc(crs_pkg::IDX_ACC_SECOND, 16'h00ff, 16'h0034);
        wr(5'h1f, 16'hffff);
        rc(5'h1f, 16'hffff, 16'h0000);
        wr(crs_pkg::IDX_BANKS, 16'h4567);
        wr(crs_pkg::IDX_INDEX_ONE, 16'hfffe);
        wr(crs_pkg::IDX_INDEX_TWO, 16'hfffd);
        wr(crs_pkg::IDX_INDEX_THREE, 16'hfffc);
        settle();
        chk(index_one_addr, 20'h5fffe);
        chk(index_two_addr, 20'h6fffd);
        chk(index_three_addr, 20'h7fffc);
        wr(crs_pkg::IDX_STACK, 16'h0000);
        wr(crs_pkg::IDX_STACK_BANK, 16'h0003);
        settle();
        chk(stack_addr, 20'h30000);
        foreach (ops[i])
        begin
            i_crs_exec_model.stack_op(ops[i]);
            settle();
            chk(stack_addr, exps[i]);
        end
        i_crs_exec_model.pc_op(2'h2, 16'h1235);
        wr(crs_pkg::IDX_FLAGS, 16'h80e9);
        i_crs_exec_model.pc_op(2'h1, 16'h0000);
        settle();
        chk(fetch_addr, 20'h91236);
        rc(crs_pkg::IDX_PROGRAM, 16'hffff, 16'h1237);
        wr(crs_pkg::IDX_FLAGS, 16'h0060);
        settle();
        chk(interrupt_priority_mask, 3'h3);
        for (int i = 0; i < 4; i++)
        begin
            i_crs_exec_model.flag_op(8'(1 << i), 8'hff, 4'h0);
            rc(crs_pkg::IDX_FLAGS, 16'hff00, 16'(((1 << (i + 1)) - 1) << 8));
        end
        i_crs_exec_model.flag_op(8'h05, 8'h00, 4'h0);
        i_crs_exec_model.flag_op(8'h00, 8'h00, 4'h2);
        rc(crs_pkg::IDX_FLAGS, 16'hff00, 16'h0a00);
        i_crs_exec_model.flag_op(8'h00, 8'h00, 4'h5);
        i_crs_exec_model.mac_op(36'h080000000, 36'h000000000);
        rc(crs_pkg::IDX_FLAGS, 16'hff00, 16'h3a00);
        i_crs_exec_model.mac_op(36'h800000000, 36'h7ffffffff);
        rc(crs_pkg::IDX_FLAGS, 16'hff00, 16'h7a00);
        rc(crs_pkg::IDX_MAC_SAT_READ, 16'hffff, 16'h0000);
        wr(crs_pkg::IDX_FLAGS, 16'h7a70);
        rc(crs_pkg::IDX_MAC_SAT_READ, 16'hffff, 16'hffff);
        i_crs_exec_model.flag_op(8'h00, 8'h00, 4'h8);
        watch(seen);
        chk(seen, 20'h00001);
        wr(crs_pkg::IDX_FLAGS, 16'h8000);
        i_crs_exec_model.flag_op(8'h00, 8'h00, 4'h8);
        watch(seen);
        chk(seen, 20'h00000);
        close_out();
    end
endmodule
`default_nettype wire
